/* File: dv/hrt_regs_test.sv */
// self-checking bench for the header receive and test bus register bank
// assumes hrt_pkg and hrt_regs are compiled first; the bench drives every input port
`timescale 1ns/1ps
`default_nettype none
module hrt_regs_test;
  import hrt_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic [HRT_AW-1:0] reg_addr;
  logic [HRT_DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [HRT_DW-1:0] reg_rdata;
  logic rx_active;
  logic fixed_len_mode;
  logic rx_hdr_valid;
  logic [HRT_HDR_W-1:0] rx_hdr_data;
  logic rx_len_valid;
  logic [HRT_DW-1:0] rx_len_data;
  logic [15:0] hdr_mask_upper;
  logic [HRT_HDR_W-1:0] check_header;
  logic header_match;
  logic [HRT_ANA_POINTS-1:0] analog_points_pos;
  logic [HRT_ANA_POINTS-1:0] analog_points_neg;
  logic analog_probe_out_pos;
  logic analog_probe_out_neg;
  logic [HRT_DIG_POINTS-1:0] digital_points;
  logic digital_probe_out;
  logic gpio0_in;
  logic scan_shift_enable_input;
  int err_count;
  int num_checks;
  // last entry is unmapped and must read as zero
  localparam logic [6:0] OFS [10] = '{HRT_OFS_HDR_MASK1, HRT_OFS_HDR_MASK0, HRT_OFS_RX_HDR3, HRT_OFS_RX_HDR2,
    HRT_OFS_RX_HDR1, HRT_OFS_RX_HDR0, HRT_OFS_RX_PKT_LEN, HRT_OFS_ANA_SEL, HRT_OFS_DIG_SEL, 7'h7F};
  localparam logic [7:0] RST [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

  hrt_regs u_hrt_regs (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_active(rx_active),
    .fixed_len_mode(fixed_len_mode), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_data(rx_hdr_data),
    .rx_len_valid(rx_len_valid), .rx_len_data(rx_len_data), .hdr_mask_upper(hdr_mask_upper),
    .check_header(check_header), .header_match(header_match), .analog_points_pos(analog_points_pos),
    .analog_points_neg(analog_points_neg), .analog_probe_out_pos(analog_probe_out_pos),
    .analog_probe_out_neg(analog_probe_out_neg), .digital_points(digital_points),
    .digital_probe_out(digital_probe_out), .gpio0_in(gpio0_in), .scan_shift_enable_input(scan_shift_enable_input));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data is valid only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg_%0h", a), {24'h0, reg_rdata}, {24'h0, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic len_pulse(input logic [7:0] d);
    @(posedge sys_clk);
    rx_len_data <= d;
    rx_len_valid <= 1'b1;
    @(posedge sys_clk);
    rx_len_valid <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge sys_clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, rx_active, fixed_len_mode, rx_hdr_valid} = '0;
    {rx_hdr_data, rx_len_valid, rx_len_data, hdr_mask_upper, check_header, gpio0_in} = '0;
    {analog_points_pos, analog_points_neg, digital_points} = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (OFS[i]) rd(OFS[i], RST[i]);
    // read-only and unmapped places ignore writes
    wr(HRT_OFS_RX_HDR2, 8'hAA);
    wr(HRT_OFS_RX_PKT_LEN, 8'h01);
    wr(7'h7F, 8'h55);
    rd(HRT_OFS_RX_HDR2, 8'h00);
    rd(HRT_OFS_RX_PKT_LEN, 8'hFF);
    rd(7'h7F, 8'h00);
    wr(HRT_OFS_HDR_MASK1, 8'hA5);
    // read straight after the write, with no idle cycle between
    fork
      wr(HRT_OFS_HDR_MASK0, 8'h5A);
      begin
        @(posedge sys_clk);
        rd(HRT_OFS_HDR_MASK0, 8'h5A);
      end
    join
    rd(HRT_OFS_HDR_MASK1, 8'hA5);
    idle(1);
    chk("rdata_after", {24'h0, reg_rdata}, 32'h0);
    // header capture and byte order
    @(posedge sys_clk);
    rx_hdr_data <= 32'h1234_5678;
    rx_hdr_valid <= 1'b1;
    fork
      rd(HRT_OFS_RX_HDR3, 8'h12);
      begin
        @(posedge sys_clk);
        rx_hdr_valid <= 1'b0;
        rx_hdr_data <= 32'hFFFF_FFFF;
      end
    join
    rd(HRT_OFS_RX_HDR2, 8'h34);
    rd(HRT_OFS_RX_HDR1, 8'h56);
    rd(HRT_OFS_RX_HDR0, 8'h78);
    // mismatch only in bits 15:8, which are masked off first
    @(posedge sys_clk);
    hdr_mask_upper <= 16'hFFFF;
    check_header <= 32'h1234_A978;
    wr(HRT_OFS_HDR_MASK1, 8'h00);
    wr(HRT_OFS_HDR_MASK0, 8'hFF);
    idle(3);
    chk("match_masked", {31'h0, header_match}, 32'h1);
    wr(HRT_OFS_HDR_MASK1, 8'h01);
    idle(3);
    chk("match_enabled", {31'h0, header_match}, 32'h0);
    // length capture in variable mode
    @(posedge sys_clk);
    rx_active <= 1'b1;
    len_pulse(8'h10);
    rd(HRT_OFS_RX_PKT_LEN, 8'h10);
    // fixed mode seen during reception blocks the capture
    @(posedge sys_clk);
    rx_active <= 1'b0;
    @(posedge sys_clk);
    rx_active <= 1'b1;
    fixed_len_mode <= 1'b1;
    fork
      len_pulse(8'h20);
      begin
        @(posedge sys_clk);
        fixed_len_mode <= 1'b0;
      end
    join
    rd(HRT_OFS_RX_PKT_LEN, 8'h10);
    @(posedge sys_clk);
    rx_active <= 1'b0;
    @(posedge sys_clk);
    rx_active <= 1'b1;
    len_pulse(8'h2A);
    rd(HRT_OFS_RX_PKT_LEN, 8'h2A);
    // fixed mode high at the capture strobe itself
    @(posedge sys_clk);
    fixed_len_mode <= 1'b1;
    len_pulse(8'h33);
    rd(HRT_OFS_RX_PKT_LEN, 8'h2A);
    // analog select, low, middle and top codes
    foreach (OFS[i])
    begin
      if (i < 3)
      begin
        logic [4:0] s;
        s = (i == 0) ? 5'd1 : ((i == 1) ? 5'd18 : 5'd31);
        @(posedge sys_clk);
        analog_points_pos <= 32'h1 << s;
        analog_points_neg <= ~(32'h1 << s);
        wr(HRT_OFS_ANA_SEL, {3'h0, s});
        idle(2);
        chk("ana_pos", {31'h0, analog_probe_out_pos}, 32'h1);
        chk("ana_neg", {31'h0, analog_probe_out_neg}, 32'h0);
        rd(HRT_OFS_ANA_SEL, {3'h0, s});
      end
    end
    // digital select, every pass flips the chosen point
    for (int s = 0; s < 64; s += 21)
    begin
      @(posedge sys_clk);
      digital_points <= 64'h1 << s;
      wr(HRT_OFS_DIG_SEL, s[7:0]);
      idle(2);
      chk("dig_hi", {31'h0, digital_probe_out}, 32'h1);
      @(posedge sys_clk);
      digital_points <= ~(64'h1 << s);
      idle(2);
      chk("dig_lo", {31'h0, digital_probe_out}, 32'h0);
    end
    // scan enable follows gpio0 only while bit 6 is set
    wr(HRT_OFS_DIG_SEL, 8'h40);
    @(posedge sys_clk);
    gpio0_in <= 1'b1;
    idle(8);
    chk("scan_on", {31'h0, scan_shift_enable_input}, 32'h1);
    @(posedge sys_clk);
    gpio0_in <= 1'b0;
    idle(8);
    chk("scan_low", {31'h0, scan_shift_enable_input}, 32'h0);
    @(posedge sys_clk);
    gpio0_in <= 1'b1;
    wr(HRT_OFS_DIG_SEL, 8'h00);
    idle(8);
    chk("scan_gated", {31'h0, scan_shift_enable_input}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: src/hrt_hdr_cmp.sv */
// masked compare of received header against check header
// assumes all inputs come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module hrt_hdr_cmp
(
  // operands
  input wire logic [hrt_pkg::HRT_HDR_W-1:0] rx_header,
  input wire logic [hrt_pkg::HRT_HDR_W-1:0] check_header,
  input wire logic [hrt_pkg::HRT_HDR_W-1:0] enable_mask,
  // result
  output logic match
);
  import hrt_pkg::*;

  // masked-off positions never cause a mismatch
  assign match = ~|((rx_header ^ check_header) & enable_mask);
endmodule
`default_nettype wire

/* File: src/hrt_pin_sync.sv */
// three-flop synchroniser with agreement filter for one pin
// assumes an asynchronous pin level and one system clock
`timescale 1ns/1ps
`default_nettype none
module hrt_pin_sync
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  import hrt_pkg::*;

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  hrt_pin_state_t state_q;

  // first flop feeds the second and nothing else
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
    end
    else
    begin
      ff1_q <= pin_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // change counts only once second and third agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= HRT_PIN_LOW;
    else if (ff2_q == ff3_q)
      state_q <= ff3_q ? HRT_PIN_HIGH : HRT_PIN_LOW;
  end

  assign level_out = (state_q == HRT_PIN_HIGH);
endmodule
`default_nettype wire

/* File: src/hrt_pkg.sv */
// shared constants for the header receive and test bus register bank
// assumes an 8-bit register port with 7-bit addresses
package hrt_pkg;
  localparam int unsigned HRT_AW = 7;
  localparam int unsigned HRT_DW = 8;

  // register offsets
  localparam logic [6:0] HRT_OFS_HDR_MASK1 = 7'h45;
  localparam logic [6:0] HRT_OFS_HDR_MASK0 = 7'h46;
  localparam logic [6:0] HRT_OFS_RX_HDR3 = 7'h47;
  localparam logic [6:0] HRT_OFS_RX_HDR2 = 7'h48;
  localparam logic [6:0] HRT_OFS_RX_HDR1 = 7'h49;
  localparam logic [6:0] HRT_OFS_RX_HDR0 = 7'h4A;
  localparam logic [6:0] HRT_OFS_RX_PKT_LEN = 7'h4B;
  localparam logic [6:0] HRT_OFS_ANA_SEL = 7'h50;
  localparam logic [6:0] HRT_OFS_DIG_SEL = 7'h51;

  // reset values
  localparam logic [7:0] HRT_RST_HDR_MASK = 8'h00;
  localparam logic [7:0] HRT_RST_RX_HDR = 8'h00;
  localparam logic [7:0] HRT_RST_RX_PKT_LEN = 8'hFF;
  localparam logic [7:0] HRT_RST_ANA_SEL = 8'h00;
  localparam logic [7:0] HRT_RST_DIG_SEL = 8'h00;
  localparam logic [7:0] HRT_RDATA_UNMAPPED = 8'h00;

  // field layout
  localparam int unsigned HRT_ANA_SEL_W = 5;
  localparam int unsigned HRT_ANA_SEL_LSB = 0;
  localparam int unsigned HRT_DIG_SEL_W = 6;
  localparam int unsigned HRT_DIG_SEL_LSB = 0;
  localparam int unsigned HRT_SCAN_EN_BIT = 6;
  localparam int unsigned HRT_HDR_W = 32;
  localparam int unsigned HRT_ANA_POINTS = 32;
  localparam int unsigned HRT_DIG_POINTS = 64;

  // synchroniser filter state
  typedef enum logic [0:0] {
    HRT_PIN_LOW = 1'b0,
    HRT_PIN_HIGH = 1'b1
  } hrt_pin_state_t;
endpackage

/* File: src/hrt_regs.sv */
// header receive and test bus register bank, device side
// assumes packet handler strobes and test points on sys_clk; gpio0 is async
//
// Overview of operation
// - two RW mask bytes, cleared at reset
// - compare only header bits whose mask is one
// - received 32-bit header held read-only
// - variable length mode captures received length byte
// - length valid only if fixed-length stayed low
// - received length resets to all ones
// - five-bit select routes analog probe pair
// - scan enable bit makes gpio0 scan input
`timescale 1ns/1ps
`default_nettype none
module hrt_regs
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [hrt_pkg::HRT_AW-1:0] reg_addr,
  input wire logic [hrt_pkg::HRT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hrt_pkg::HRT_DW-1:0] reg_rdata,
  // packet handler side
  input wire logic rx_active,
  input wire logic fixed_len_mode,
  input wire logic rx_hdr_valid,
  input wire logic [hrt_pkg::HRT_HDR_W-1:0] rx_hdr_data,
  input wire logic rx_len_valid,
  input wire logic [hrt_pkg::HRT_DW-1:0] rx_len_data,
  input wire logic [15:0] hdr_mask_upper,
  input wire logic [hrt_pkg::HRT_HDR_W-1:0] check_header,
  output logic header_match,
  // analog test bus
  input wire logic [hrt_pkg::HRT_ANA_POINTS-1:0] analog_points_pos,
  input wire logic [hrt_pkg::HRT_ANA_POINTS-1:0] analog_points_neg,
  output logic analog_probe_out_pos,
  output logic analog_probe_out_neg,
  // digital test bus and scan
  input wire logic [hrt_pkg::HRT_DIG_POINTS-1:0] digital_points,
  output logic digital_probe_out,
  input wire logic gpio0_in,
  output logic scan_shift_enable_input
);
  import hrt_pkg::*;

  logic [7:0] hdr_mask1_q;
  logic [7:0] hdr_mask0_q;
  logic [HRT_HDR_W-1:0] rx_hdr_q;
  logic [7:0] rx_len_q;
  logic [7:0] ana_sel_q;
  logic [7:0] dig_sel_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic fixlen_seen_q;
  logic match_q;
  logic match_w;
  logic gpio0_level;
  logic ana_pos_q;
  logic ana_neg_q;
  logic dig_out_q;
  logic scan_q;
  logic [HRT_ANA_SEL_W-1:0] ana_field;
  logic [HRT_DIG_SEL_W-1:0] dig_field;

  function automatic logic wr_hit(input logic wr, input logic [6:0] addr, input logic [6:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  assign ana_field = ana_sel_q[HRT_ANA_SEL_LSB +: HRT_ANA_SEL_W];
  assign dig_field = dig_sel_q[HRT_DIG_SEL_LSB +: HRT_DIG_SEL_W];

  // mask bytes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_mask1_q <= HRT_RST_HDR_MASK;
      hdr_mask0_q <= HRT_RST_HDR_MASK;
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, HRT_OFS_HDR_MASK1))
        hdr_mask1_q <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, HRT_OFS_HDR_MASK0))
        hdr_mask0_q <= reg_wdata;
    end
  end

  // received header, no write path on purpose
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_hdr_q <= {4{HRT_RST_RX_HDR}};
    else if (rx_hdr_valid)
      rx_hdr_q <= rx_hdr_data;
  end

  // fixed-length seen at any time during the current reception
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fixlen_seen_q <= 1'b0;
    else if (!rx_active)
      fixlen_seen_q <= 1'b0;
    else if (fixed_len_mode)
      fixlen_seen_q <= 1'b1;
  end

  // received length; in fixed mode software reads the packet length register instead
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_len_q <= HRT_RST_RX_PKT_LEN;
    else if (rx_len_valid && !fixed_len_mode && !fixlen_seen_q)
      rx_len_q <= rx_len_data;
  end

  // test bus selects, reserved bits stored as written
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ana_sel_q <= HRT_RST_ANA_SEL;
      dig_sel_q <= HRT_RST_DIG_SEL;
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, HRT_OFS_ANA_SEL))
        ana_sel_q <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, HRT_OFS_DIG_SEL))
        dig_sel_q <= reg_wdata;
    end
  end

  // read mux
  always_comb
  begin
    rdata_d = HRT_RDATA_UNMAPPED;
    case (reg_addr)
      HRT_OFS_HDR_MASK1: rdata_d = hdr_mask1_q;
      HRT_OFS_HDR_MASK0: rdata_d = hdr_mask0_q;
      HRT_OFS_RX_HDR3: rdata_d = rx_hdr_q[31:24];
      HRT_OFS_RX_HDR2: rdata_d = rx_hdr_q[23:16];
      HRT_OFS_RX_HDR1: rdata_d = rx_hdr_q[15:8];
      HRT_OFS_RX_HDR0: rdata_d = rx_hdr_q[7:0];
      HRT_OFS_RX_PKT_LEN: rdata_d = rx_len_q;
      HRT_OFS_ANA_SEL: rdata_d = ana_sel_q;
      HRT_OFS_DIG_SEL: rdata_d = dig_sel_q;
      default: rdata_d = HRT_RDATA_UNMAPPED;
    endcase
  end

  // read data valid only in the cycle after the strobe
  // zero outside the answer cycle, so a stale byte never looks like data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= HRT_RDATA_UNMAPPED;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= HRT_RDATA_UNMAPPED;
  end

  assign reg_rdata = rdata_q;

  // masked header compare
  hrt_hdr_cmp u_cmp (
    .rx_header(rx_hdr_q),
    .check_header(check_header),
    .enable_mask({hdr_mask_upper, hdr_mask1_q, hdr_mask0_q}),
    .match(match_w)
  );

  // registered, so a mask or header change shows one cycle later
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      match_q <= 1'b0;
    else
      match_q <= match_w;
  end

  assign header_match = match_q;

  // test probe muxes; registered, so one cycle behind the select
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ana_pos_q <= 1'b0;
      ana_neg_q <= 1'b0;
      dig_out_q <= 1'b0;
    end
    else
    begin
      ana_pos_q <= analog_points_pos[ana_field];
      ana_neg_q <= analog_points_neg[ana_field];
      dig_out_q <= digital_points[dig_field];
    end
  end

  assign analog_probe_out_pos = ana_pos_q;
  assign analog_probe_out_neg = ana_neg_q;
  assign digital_probe_out = dig_out_q;

  // gpio0 is asynchronous, so it is filtered before use
  hrt_pin_sync u_gpio0_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(gpio0_in),
    .level_out(gpio0_level)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      scan_q <= 1'b0;
    else
      scan_q <= dig_sel_q[HRT_SCAN_EN_BIT] & gpio0_level;
  end

  assign scan_shift_enable_input = scan_q;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_MASK_WRITE: assert property (
    reg_wr && reg_addr == HRT_OFS_HDR_MASK1 |=> hdr_mask1_q == $past(reg_wdata))
    else $error("mask byte 1 did not take the write");

  AST_MASK_READBACK: assert property (
    reg_wr && reg_addr == HRT_OFS_HDR_MASK0 ##1 reg_rd && reg_addr == HRT_OFS_HDR_MASK0 && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask byte 0 read back wrong");

  AST_MASKED_MATCH: assert property (
    ((rx_hdr_q ^ check_header) & {hdr_mask_upper, hdr_mask1_q, hdr_mask0_q}) == '0
    ##1 $stable(rx_hdr_q) |-> header_match)
    else $error("masked header compare missed a match");

  AST_HDR_RO: assert property (
    reg_wr && !rx_hdr_valid |=> $stable(rx_hdr_q))
    else $error("received header changed without a capture");

  AST_HDR_CAPTURE: assert property (
    rx_hdr_valid ##1 reg_rd && reg_addr == HRT_OFS_RX_HDR3 && !rx_hdr_valid
    |=> reg_rdata == $past(rx_hdr_data[31:24], 2))
    else $error("header byte 3 read wrong after capture");

  AST_LEN_CAPTURE: assert property (
    rx_len_valid && !fixed_len_mode && !fixlen_seen_q |=> rx_len_q == $past(rx_len_data))
    else $error("length byte not captured in variable mode");

  AST_LEN_FIXED_HOLD: assert property (
    fixed_len_mode && rx_active ##1 (rx_active && !fixed_len_mode && rx_len_valid) |=> $stable(rx_len_q))
    else $error("length captured although fixed mode was seen");

  AST_SCAN_GATE: assert property (
    !dig_sel_q[HRT_SCAN_EN_BIT] |=> !scan_shift_enable_input)
    else $error("scan enable active while scan test bit is clear");

  AST_DIG_ROUTE: assert property (
    1'b1 |=> digital_probe_out == $past(digital_points[dig_field]))
    else $error("digital probe does not follow the select");

  AST_ANA_ROUTE: assert property (
    1'b1 |=> analog_probe_out_pos == $past(analog_points_pos[ana_field])
    && analog_probe_out_neg == $past(analog_points_neg[ana_field]))
    else $error("analog probe pair does not follow the select");

  AST_RD_ONE_CYCLE: assert property (
    !reg_rd |=> reg_rdata == HRT_RDATA_UNMAPPED)
    else $error("read data stood beyond its cycle");

  // mask bytes only move on their own write
  AST_MASK_HOLD: assert property (
    !(reg_wr && (reg_addr == HRT_OFS_HDR_MASK1 || reg_addr == HRT_OFS_HDR_MASK0))
    |=> $stable(hdr_mask1_q) && $stable(hdr_mask0_q))
    else $error("mask byte changed without a write");

  AST_MASK0_WRITE: assert property (
    reg_wr && reg_addr == HRT_OFS_HDR_MASK0 |=> hdr_mask0_q == $past(reg_wdata))
    else $error("mask byte 0 did not take the write");

  AST_MASKED_MISS: assert property (
    ((rx_hdr_q ^ check_header) & {hdr_mask_upper, hdr_mask1_q, hdr_mask0_q}) != '0
    |=> !header_match)
    else $error("masked header compare missed a difference");

  // received header and length
  AST_HDR_HOLD: assert property (
    !rx_hdr_valid |=> $stable(rx_hdr_q))
    else $error("received header changed without a capture");

  AST_HDR_CAPTURE_ALL: assert property (
    rx_hdr_valid |=> rx_hdr_q == $past(rx_hdr_data))
    else $error("received header not captured");

  AST_HDR_BYTE0_READ: assert property (
    reg_rd && reg_addr == HRT_OFS_RX_HDR0 |=> reg_rdata == $past(rx_hdr_q[7:0]))
    else $error("header byte 0 read from the wrong lane");

  AST_LEN_READ: assert property (
    reg_rd && reg_addr == HRT_OFS_RX_PKT_LEN |=> reg_rdata == $past(rx_len_q))
    else $error("received length read wrong");

  AST_LEN_HOLD: assert property (
    !rx_len_valid |=> $stable(rx_len_q))
    else $error("received length changed without a capture");

  AST_LEN_FIXED_NOW: assert property (
    rx_len_valid && fixed_len_mode |=> $stable(rx_len_q))
    else $error("length captured while fixed mode is set");

  // test bus selects and scan
  AST_ANA_SEL_WRITE: assert property (
    reg_wr && reg_addr == HRT_OFS_ANA_SEL |=> ana_sel_q == $past(reg_wdata))
    else $error("analog select did not take the write");

  AST_DIG_SEL_WRITE: assert property (
    reg_wr && reg_addr == HRT_OFS_DIG_SEL |=> dig_sel_q == $past(reg_wdata))
    else $error("digital select did not take the write");

  AST_DIG_SEL_READ: assert property (
    reg_rd && reg_addr == HRT_OFS_DIG_SEL |=> reg_rdata == $past(dig_sel_q))
    else $error("digital select read wrong");

  AST_SCAN_FOLLOW: assert property (
    dig_sel_q[HRT_SCAN_EN_BIT] && gpio0_level |=> scan_shift_enable_input)
    else $error("scan enable missed the filtered pin");

  // covers for the main scenarios
  COV_LEN_CAPTURE: cover property (rx_len_valid && !fixed_len_mode ##1 reg_rd && reg_addr == HRT_OFS_RX_PKT_LEN);
  COV_FIXED_BLOCK: cover property (fixed_len_mode && rx_active ##1 rx_len_valid && !fixed_len_mode);
  COV_WR_THEN_RD: cover property (reg_wr ##1 reg_rd);
  COV_MATCH: cover property ($rose(header_match));
  COV_SCAN: cover property ($rose(scan_shift_enable_input));
endmodule
`default_nettype wire
